/* File: core/mie_core.sv */
// Instruction execute core with Avalon-MM register access.
`timescale 1ns/1ps
`default_nettype none
module mie_core #(
	parameter int TCY_CYC = mie_pkg::TCY_CYCLES,
	parameter int STACK_DEPTH = mie_pkg::STACK_DEPTH,
	parameter int WDT_PRESC_W = mie_pkg::WDT_PRESC_W
) (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [mie_pkg::AVS_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_zero_flag,
	output logic o_timeout_flag_n,
	output logic o_powerdown_flag_n,
	output logic [mie_pkg::PC_W-1:0] o_pc
);
	import mie_pkg::*;

	localparam int DIV_W = $clog2(TCY_CYC + 1);
	localparam int SP_W = $clog2(STACK_DEPTH);
	localparam logic [DIV_W-1:0] DIV_RELOAD = DIV_W'(TCY_CYC - 1);

	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) res[i*8 +: 8] = wd[i*8 +: 8];
		end
		return res;
	endfunction : merge_be

	mie_state_e state_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic [DIV_W-1:0] div_ff;
	logic tick_ff;
	logic [INSTR_W-1:0] instr_ff;
	logic skip_ff;
	logic [DATA_W-1:0] work_ff;
	logic zero_ff;
	logic [PC_W-1:0] pc_ff;
	logic [PAGE_W-1:0] page_ff;
	logic [FADDR_W-1:0] faddr_ff;
	logic [SP_W-1:0] sp_ff;
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	logic [DATA_W-1:0] file_mem [2**FADDR_W];
	logic [WDT_PRESC_W-1:0] presc_ff;
	logic [DATA_W-1:0] wdt_ff;
	logic tmo_n_ff;
	logic pd_n_ff;

	mie_op_e op;
	logic [DATA_W-1:0] result;
	logic result_zero;
	logic wr_file;
	logic wr_work;
	logic wr_zero;
	logic skip;
	logic branch;
	logic [FADDR_W-1:0] ex_faddr;
	logic fire;
	logic fire2;
	logic bus_take;
	logic bus_wr;
	logic [3:0] reg_idx;
	logic [31:0] nxt_rdata;
	logic [PC_W-1:0] stack_top;
	logic [PC_W-1:0] branch_target;

	assign ex_faddr = instr_ff[FADDR_W-1:0];
	assign fire = (state_ff == ST_FIRST) && tick_ff;
	assign fire2 = (state_ff == ST_SECOND) && tick_ff;
	assign bus_take = (state_ff == ST_IDLE) && wait_ff && (i_avs_read || i_avs_write);
	assign bus_wr = bus_take && i_avs_write;
	assign reg_idx = i_avs_address[5:2];
	assign stack_top = stack_mem[sp_ff - SP_W'(1)];
	assign branch_target = {page_ff[4:3], instr_ff[LIT_W-1:0]};

	mie_exec_unit mie_exec_unit_inst (
		.i_instr(instr_ff),
		.i_file_data(file_mem[ex_faddr]),
		.o_op(op),
		.o_result(result),
		.o_result_zero(result_zero),
		.o_write_file(wr_file),
		.o_write_work(wr_work),
		.o_write_zero(wr_zero),
		.o_skip(skip),
		.o_branch(branch)
	);

	// instruction cycle enable
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			div_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= (div_ff == '0);
			div_ff <= (div_ff == '0) ? DIV_RELOAD : div_ff - DIV_W'(1);
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (i_avs_address)
			REG_STATUS: begin
				nxt_rdata[ST_ZERO_BIT] = zero_ff;
				nxt_rdata[ST_PD_BIT] = pd_n_ff;
				nxt_rdata[ST_TMO_BIT] = tmo_n_ff;
				nxt_rdata[ST_SKIP_BIT] = skip_ff;
				nxt_rdata[ST_BUSY_BIT] = (state_ff != ST_IDLE);
			end
			REG_INSTR: nxt_rdata[INSTR_W-1:0] = instr_ff;
			REG_WORK: nxt_rdata[DATA_W-1:0] = work_ff;
			REG_PC: nxt_rdata[PC_W-1:0] = pc_ff;
			REG_PAGE: nxt_rdata[PAGE_W-1:0] = page_ff;
			REG_STACK: nxt_rdata[PC_W-1:0] = stack_top;
			REG_FADDR: nxt_rdata[FADDR_W-1:0] = faddr_ff;
			REG_FDATA: nxt_rdata[DATA_W-1:0] = file_mem[faddr_ff];
			REG_WDT: nxt_rdata[DATA_W-1:0] = wdt_ff;
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	// bus handshake and sequencing; instruction writes hold waitrequest until done
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			state_ff <= ST_IDLE;
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
			instr_ff <= '0;
			skip_ff <= 1'b0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (!wait_ff) begin
						wait_ff <= 1'b1;
					end else if (bus_wr && (i_avs_address == REG_INSTR)) begin
						instr_ff <= INSTR_W'(merge_be({18'h00000, instr_ff}, i_avs_writedata,
							i_avs_byteenable));
						state_ff <= ST_FIRST;
					end else if (bus_take) begin
						rdata_ff <= i_avs_read ? nxt_rdata : 32'h0000_0000;
						wait_ff <= 1'b0;
					end
				end
				ST_FIRST: begin
					if (fire) begin
						skip_ff <= skip;
						if (skip || branch) begin
							state_ff <= ST_SECOND;
						end else begin
							state_ff <= ST_IDLE;
							rdata_ff <= 32'h0000_0000;
							wait_ff <= 1'b0;
						end
					end
				end
				ST_SECOND: begin
					// forced no-op cycle
					if (fire2) begin
						state_ff <= ST_IDLE;
						skip_ff <= 1'b0;
						rdata_ff <= 32'h0000_0000;
						wait_ff <= 1'b0;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					wait_ff <= 1'b1;
				end
			endcase
		end
	end

	// program counter and page latch
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			pc_ff <= PC_RST;
			page_ff <= PAGE_RST;
		end else begin
			if (bus_wr && i_avs_address == REG_PC)
				pc_ff <= PC_W'(merge_be({19'h00000, pc_ff}, i_avs_writedata,
					i_avs_byteenable));
			else if (fire)
				pc_ff <= branch ? branch_target : pc_ff + PC_W'(1);
			else if (fire2 && skip_ff)
				pc_ff <= pc_ff + PC_W'(1);
			if (bus_wr && i_avs_address == REG_PAGE)
				page_ff <= PAGE_W'(merge_be({27'h0000000, page_ff}, i_avs_writedata,
					i_avs_byteenable));
		end
	end

	// return stack, wraps when overfilled
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			sp_ff <= '0;
			for (int i = 0; i < STACK_DEPTH; i++) stack_mem[i] <= PC_RST;
		end else if (fire && op == OP_CALL) begin
			stack_mem[sp_ff] <= pc_ff + PC_W'(1);
			sp_ff <= sp_ff + SP_W'(1);
		end
	end

	// work register and zero flag
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			work_ff <= WORK_RST;
			zero_ff <= 1'b0;
		end else begin
			if (bus_wr && i_avs_address == REG_WORK)
				work_ff <= DATA_W'(merge_be({24'h000000, work_ff}, i_avs_writedata,
					i_avs_byteenable));
			else if (fire && wr_work)
				work_ff <= result;
			if (fire && wr_zero)
				zero_ff <= result_zero;
		end
	end

	// file registers; contents are undefined until written
	always_ff @(posedge i_core_clk) begin
		if (bus_wr && i_avs_address == REG_FDATA && i_avs_byteenable[0])
			file_mem[faddr_ff] <= i_avs_writedata[DATA_W-1:0];
		else if (fire && wr_file)
			file_mem[ex_faddr] <= result;
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset)
			faddr_ff <= '0;
		else if (bus_wr && i_avs_address == REG_FADDR)
			faddr_ff <= FADDR_W'(merge_be({25'h0000000, faddr_ff}, i_avs_writedata,
				i_avs_byteenable));
	end

	// watchdog; the clear wins over a same-cycle overflow since it restarts the count
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			presc_ff <= '0;
			wdt_ff <= WDT_RST;
			tmo_n_ff <= 1'b1;
			pd_n_ff <= 1'b1;
		end else if (fire && op == OP_WATCHDOG_CLEAR) begin
			presc_ff <= '0;
			wdt_ff <= WDT_RST;
			tmo_n_ff <= 1'b1;
			pd_n_ff <= 1'b1;
		end else if (tick_ff) begin
			presc_ff <= presc_ff + WDT_PRESC_W'(1);
			if (&presc_ff) begin
				wdt_ff <= wdt_ff + 8'h01;
				if (&wdt_ff) tmo_n_ff <= 1'b0;
			end
		end
	end

	assign o_avs_readdata = rdata_ff;
	assign o_avs_waitrequest = wait_ff;
	assign o_zero_flag = zero_ff;
	assign o_timeout_flag_n = tmo_n_ff;
	assign o_powerdown_flag_n = pd_n_ff;
	assign o_pc = pc_ff;

	// checking helpers
	logic [FADDR_W-1:0] chk_addr_q;
	logic [7:0] chk_file_q;
	always_ff @(posedge i_core_clk) begin
		chk_addr_q <= ex_faddr;
		chk_file_q <= file_mem[ex_faddr];
	end

	default clocking chk_cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);

	chk_two_cycle: assert property (
		fire && (skip || branch) |=> state_ff == ST_SECOND ##[1:8] wait_ff == 1'b0)
		else $error("two-cycle instruction did not take a second cycle");
	chk_single_cycle: assert property (
		fire && !skip && !branch |=> state_ff == ST_IDLE && !wait_ff)
		else $error("single-cycle instruction was not acknowledged");
	chk_skip_set: assert property (
		fire && op == OP_BIT_SKIP_SET && !file_mem[ex_faddr][instr_ff[9:7]]
		|=> !skip_ff && pc_ff == $past(pc_ff) + PC_W'(1))
		else $error("skip-if-set skipped on a clear bit");
	chk_skip_clear: assert property (
		fire && op == OP_BIT_SKIP_CLEAR && !file_mem[ex_faddr][instr_ff[9:7]] |=> skip_ff)
		else $error("skip-if-clear missed a clear bit");
	chk_clear_file: assert property (
		fire && op == OP_CLEAR_FILE |=> file_mem[chk_addr_q] == 8'h00 && zero_ff)
		else $error("clear file left data or zero flag");
	chk_clear_work: assert property (
		fire && op == OP_CLEAR_WORK |=> work_ff == 8'h00 && zero_ff)
		else $error("clear work left data or zero flag");
	chk_call_push: assert property (
		fire && op == OP_CALL |=> stack_top == $past(pc_ff) + PC_W'(1)
		&& pc_ff == {$past(page_ff[4:3]), $past(instr_ff[LIT_W-1:0])})
		else $error("call pushed or loaded a wrong address");
	chk_branch_stack: assert property (
		fire && op == OP_BRANCH |=> $stable(sp_ff)
		&& pc_ff == {$past(page_ff[4:3]), $past(instr_ff[LIT_W-1:0])})
		else $error("branch disturbed stack or loaded wrong address");
	chk_watchdog_clear: assert property (
		fire && op == OP_WATCHDOG_CLEAR |=> wdt_ff == 8'h00 && presc_ff == '0)
		else $error("watchdog clear left counts running");
	chk_flags_set: assert property (
		fire && op == OP_WATCHDOG_CLEAR |=> (tmo_n_ff && pd_n_ff) [*2])
		else $error("watchdog clear did not set status flags");
	chk_complement_work: assert property (
		fire && op == OP_COMPLEMENT && !instr_ff[7] |=> work_ff == ~chk_file_q)
		else $error("complement to work gave wrong value");
	chk_dec_zero: assert property (
		fire && op == OP_DECREMENT && instr_ff[7] |=> file_mem[chk_addr_q] == chk_file_q - 8'h01
		&& zero_ff == (chk_file_q == 8'h01))
		else $error("decrement result or zero flag wrong");
	chk_inc_zero: assert property (
		fire && op == OP_INCREMENT && !instr_ff[7] |=> work_ff == chk_file_q + 8'h01
		&& zero_ff == (chk_file_q == 8'hFF))
		else $error("increment result or zero flag wrong");
	chk_skipz_flags: assert property (
		fire && (op == OP_DEC_SKIP_ZERO || op == OP_INC_SKIP_ZERO) |=> $stable(zero_ff))
		else $error("skip-on-zero altered the zero flag");
	chk_inc_skip: assert property (
		fire && op == OP_INC_SKIP_ZERO && file_mem[ex_faddr] == 8'hFF |=> skip_ff)
		else $error("increment-skip missed a wrap to zero");
	chk_dec_skip: assert property (
		fire && op == OP_DEC_SKIP_ZERO && file_mem[ex_faddr] == 8'h01 |=> skip_ff)
		else $error("decrement-skip missed a zero result");
	chk_zero_meaning: assert property (
		fire && op == OP_COMPLEMENT |=> zero_ff == (chk_file_q == 8'hFF))
		else $error("zero flag disagrees with complement result");

	cov_skip_taken: cover property (fire && skip ##[1:8] fire2);
	cov_call: cover property (fire && op == OP_CALL);
	cov_branch: cover property (fire && op == OP_BRANCH);
	cov_dec_skip: cover property (fire && op == OP_DEC_SKIP_ZERO && skip);
	cov_timeout: cover property ($fell(tmo_n_ff));
endmodule : mie_core
`default_nettype wire

/* File: core/mie_exec_unit.sv */
// Instruction decode and data path for one executed instruction.
`timescale 1ns/1ps
`default_nettype none
module mie_exec_unit (
	input wire logic [mie_pkg::INSTR_W-1:0] i_instr,
	input wire logic [mie_pkg::DATA_W-1:0] i_file_data,
	output mie_pkg::mie_op_e o_op,
	output logic [mie_pkg::DATA_W-1:0] o_result,
	output logic o_result_zero,
	output logic o_write_file,
	output logic o_write_work,
	output logic o_write_zero,
	output logic o_skip,
	output logic o_branch
);
	import mie_pkg::*;

	function automatic mie_op_e decode_op(input logic [INSTR_W-1:0] ins);
		mie_op_e op;
		op = OP_NOP;
		if (ins == PAT_WDT_CLR) op = OP_WATCHDOG_CLEAR;
		else if (ins[13:7] == PAT_CLEAR_FILE_OP) op = OP_CLEAR_FILE;
		else if (ins[13:7] == PAT_CLEAR_WORK_OP) op = OP_CLEAR_WORK;
		else if (ins[13:8] == PAT_COMPLEMENT_FILE_OP) op = OP_COMPLEMENT;
		else if (ins[13:8] == PAT_DECREMENT_FILE_OP) op = OP_DECREMENT;
		else if (ins[13:8] == PAT_INCREMENT_FILE_OP) op = OP_INCREMENT;
		else if (ins[13:8] == PAT_DECREMENT_SKIP_ZERO_OP) op = OP_DEC_SKIP_ZERO;
		else if (ins[13:8] == PAT_INCREMENT_SKIP_ZERO_OP) op = OP_INC_SKIP_ZERO;
		else if (ins[13:10] == PAT_BSKIP_SET) op = OP_BIT_SKIP_SET;
		else if (ins[13:10] == PAT_BSKIP_CLR) op = OP_BIT_SKIP_CLEAR;
		else if (ins[13:11] == PAT_CALL) op = OP_CALL;
		else if (ins[13:11] == PAT_BRANCH) op = OP_BRANCH;
		return op;
	endfunction : decode_op

	logic dest_file;
	logic tested_bit;

	always_comb begin
		o_op = decode_op(i_instr);
		dest_file = i_instr[7];
		tested_bit = i_file_data[i_instr[9:7]];
		o_result = i_file_data;
		o_write_file = 1'b0;
		o_write_work = 1'b0;
		o_write_zero = 1'b0;
		o_skip = 1'b0;
		o_branch = 1'b0;
		unique case (o_op)
			OP_CLEAR_FILE: begin
				o_result = '0;
				o_write_file = 1'b1;
				o_write_zero = 1'b1;
			end
			OP_CLEAR_WORK: begin
				o_result = '0;
				o_write_work = 1'b1;
				o_write_zero = 1'b1;
			end
			OP_COMPLEMENT, OP_DECREMENT, OP_INCREMENT: begin
				if (o_op == OP_COMPLEMENT) o_result = ~i_file_data;
				else if (o_op == OP_DECREMENT) o_result = i_file_data - 8'h01;
				else o_result = i_file_data + 8'h01;
				o_write_file = dest_file;
				o_write_work = ~dest_file;
				o_write_zero = 1'b1;
			end
			OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO: begin
				// flags deliberately left alone
				if (o_op == OP_DEC_SKIP_ZERO) o_result = i_file_data - 8'h01;
				else o_result = i_file_data + 8'h01;
				o_write_file = dest_file;
				o_write_work = ~dest_file;
				o_skip = (o_result == 8'h00);
			end
			OP_BIT_SKIP_SET: o_skip = tested_bit;
			OP_BIT_SKIP_CLEAR: o_skip = ~tested_bit;
			OP_CALL, OP_BRANCH: o_branch = 1'b1;
			OP_NOP, OP_WATCHDOG_CLEAR: begin
			end
		endcase
		o_result_zero = (o_result == 8'h00);
	end
endmodule : mie_exec_unit
`default_nettype wire

/* File: core/mie_pkg.sv */
package mie_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TCY_NS = 40;
	localparam int TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INSTR_W = 14;
	localparam int PC_W = 13;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PAGE_W = 5;
	localparam int LIT_W = 11;
	localparam int STACK_DEPTH = 8;
	localparam int WDT_PRESC_W = 7;
	localparam int AVS_ADDR_W = 6;
	// register byte offsets
	localparam logic [5:0] REG_INSTR = 6'h00;
	localparam logic [5:0] REG_STATUS = 6'h04;
	localparam logic [5:0] REG_WORK = 6'h08;
	localparam logic [5:0] REG_PC = 6'h0C;
	localparam logic [5:0] REG_PAGE = 6'h10;
	localparam logic [5:0] REG_STACK = 6'h14;
	localparam logic [5:0] REG_FADDR = 6'h18;
	localparam logic [5:0] REG_FDATA = 6'h1C;
	localparam logic [5:0] REG_WDT = 6'h20;
	// status register fields
	localparam int ST_ZERO_BIT = 2;
	localparam int ST_PD_BIT = 3;
	localparam int ST_TMO_BIT = 4;
	localparam int ST_SKIP_BIT = 6;
	localparam int ST_BUSY_BIT = 7;
	// reset values
	localparam logic [PC_W-1:0] PC_RST = 13'h0000;
	localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
	localparam logic [PAGE_W-1:0] PAGE_RST = 5'h00;
	localparam logic [DATA_W-1:0] WDT_RST = 8'h00;
	// opcode patterns
	localparam logic [6:0] PAT_CLEAR_FILE_OP = 7'h03;
	localparam logic [6:0] PAT_CLEAR_WORK_OP = 7'h02;
	localparam logic [5:0] PAT_COMPLEMENT_FILE_OP = 6'h09;
	localparam logic [5:0] PAT_DECREMENT_FILE_OP = 6'h03;
	localparam logic [5:0] PAT_INCREMENT_FILE_OP = 6'h0A;
	localparam logic [5:0] PAT_DECREMENT_SKIP_ZERO_OP = 6'h0B;
	localparam logic [5:0] PAT_INCREMENT_SKIP_ZERO_OP = 6'h0F;
	localparam logic [3:0] PAT_BSKIP_CLR = 4'h6;
	localparam logic [3:0] PAT_BSKIP_SET = 4'h7;
	localparam logic [2:0] PAT_CALL = 3'h4;
	localparam logic [2:0] PAT_BRANCH = 3'h5;
	localparam logic [13:0] PAT_WDT_CLR = 14'h0064;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_CLEAR_FILE = 4'h1,
		OP_CLEAR_WORK = 4'h2,
		OP_COMPLEMENT = 4'h3,
		OP_DECREMENT = 4'h4,
		OP_INCREMENT = 4'h5,
		OP_DEC_SKIP_ZERO = 4'h6,
		OP_INC_SKIP_ZERO = 4'h7,
		OP_BIT_SKIP_SET = 4'h8,
		OP_BIT_SKIP_CLEAR = 4'h9,
		OP_CALL = 4'hA,
		OP_BRANCH = 4'hB,
		OP_WATCHDOG_CLEAR = 4'hC
	} mie_op_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FIRST = 2'b01,
		ST_SECOND = 2'b10
	} mie_state_e;
endpackage : mie_pkg

/* File: tb/mie_core_bench.sv */
// Self-checking bench for the instruction execute core, driven over its register bus.
`timescale 1ns/1ps
`default_nettype none
module mie_core_bench;
	import mie_pkg::*;
	localparam int TCY = 1;
	logic i_core_clk;
	logic i_reset;
	logic [AVS_ADDR_W-1:0] i_avs_address;
	logic i_avs_read;
	logic i_avs_write;
	logic [31:0] i_avs_writedata;
	logic [3:0] i_avs_byteenable;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic o_zero_flag;
	logic o_timeout_flag_n;
	logic o_powerdown_flag_n;
	logic [PC_W-1:0] o_pc;
	int n_mismatch = 0;
	int checked = 0;
	int lat;
	int base;
	logic [31:0] rd;

	// short instruction cycle and prescaler keep the run and the watchdog overflow brief
	mie_core #(.TCY_CYC(TCY), .WDT_PRESC_W(1)) mie_core_inst (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.o_zero_flag(o_zero_flag),
		.o_timeout_flag_n(o_timeout_flag_n),
		.o_powerdown_flag_n(o_powerdown_flag_n),
		.o_pc(o_pc)
	);

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	task automatic tally_and_finish();
		if (n_mismatch == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one access; request held until waitrequest is sampled low at a rising edge
	task automatic bus_acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= wr;
		i_avs_read <= ~wr;
		lat = 0;
		do begin
			@(posedge i_core_clk);
			lat++;
		end while (o_avs_waitrequest !== 1'b0);
		rd = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask : bus_acc

	task automatic exec(input logic [13:0] ins);
		bus_acc(1'b1, REG_INSTR, {18'h0, ins});
	endtask : exec

	task automatic set_file(input logic [6:0] a, input logic [7:0] v);
		bus_acc(1'b1, REG_FADDR, {25'h0, a});
		bus_acc(1'b1, REG_FDATA, {24'h0, v});
	endtask : set_file

	task automatic get_file(input logic [6:0] a);
		bus_acc(1'b1, REG_FADDR, {25'h0, a});
		bus_acc(1'b0, REG_FDATA, 32'h0);
	endtask : get_file

	initial begin
		repeat (20000) @(posedge i_core_clk);
		n_mismatch++;
		tally_and_finish();
	end

	initial begin : tests
		int kinds[10] = '{0, 0, 1, 1, 2, 2, 3, 3, 4, 4};
		logic [7:0] vals[10] = '{8'hFF, 8'h0F, 8'h01, 8'h00, 8'hFF, 8'h7F, 8'h01, 8'h05, 8'hFF, 8'h10};
		logic ds[10] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
		logic [5:0] pats[5] = '{PAT_COMPLEMENT_FILE_OP, PAT_DECREMENT_FILE_OP, PAT_INCREMENT_FILE_OP, PAT_DECREMENT_SKIP_ZERO_OP, PAT_INCREMENT_SKIP_ZERO_OP};
		logic [7:0] res;
		logic skp;
		int i;
		i_reset = 1'b1;
		i_avs_address = '0;
		i_avs_read = 1'b0;
		i_avs_write = 1'b0;
		i_avs_writedata = 32'h0;
		i_avs_byteenable = 4'hF;
		repeat (5) @(posedge i_core_clk);
		i_reset <= 1'b0;
		check("pc_rst", {19'h0, o_pc}, 32'h0);
		check("pd_rst", {31'h0, o_powerdown_flag_n}, 32'h1);
		bus_acc(1'b1, 6'h24, 32'h0000_00FF);
		bus_acc(1'b0, 6'h24, 32'h0);
		check("unmapped", rd, 32'h0);
		// clear file, then clear work after zero flag has been dropped
		set_file(7'h05, 8'h5A);
		bus_acc(1'b1, REG_PC, 32'h0);
		exec({PAT_CLEAR_FILE_OP, 7'h05});
		base = lat;
		get_file(7'h05);
		check("clear_file_op_data", rd, 32'h0);
		check("clear_file_op_zero", {31'h0, o_zero_flag}, 32'h1);
		check("clear_file_op_pc", {19'h0, o_pc}, 32'h1);
		set_file(7'h7F, 8'h10);
		exec({PAT_INCREMENT_FILE_OP, 1'b1, 7'h7F});
		bus_acc(1'b1, REG_WORK, 32'h33);
		exec(14'h0103);
		bus_acc(1'b0, REG_WORK, 32'h0);
		check("clear_work_op_work", rd, 32'h0);
		check("clear_work_op_zero", {31'h0, o_zero_flag}, 32'h1);
		// arithmetic table; zero flag preset opposite to whether the result is zero
		for (i = 0; i < 10; i++) begin
			res = (kinds[i] == 0) ? ~vals[i] : (kinds[i] == 1 || kinds[i] == 3) ? vals[i] - 8'h01 : vals[i] + 8'h01;
			skp = (kinds[i] >= 3) && (res == 8'h00);
			if (res == 8'h00) begin
				set_file(7'h7F, 8'h00);
				exec({PAT_INCREMENT_FILE_OP, 1'b1, 7'h7F});
			end else begin
				exec(14'h0103);
			end
			bus_acc(1'b1, REG_WORK, 32'h3C);
			bus_acc(1'b1, REG_PC, 32'h100);
			set_file(7'h30, vals[i]);
			exec({pats[kinds[i]], ds[i], 7'h30});
			check("arith_lat", lat, base + (skp ? TCY : 0));
			check("arith_pc", {19'h0, o_pc}, 32'h101 + {31'h0, skp});
			check("arith_zero", {31'h0, o_zero_flag}, {31'h0, (kinds[i] >= 3) ^ (res == 8'h00)});
			get_file(7'h30);
			check("arith_file", rd, {24'h0, ds[i] ? res : vals[i]});
			bus_acc(1'b0, REG_WORK, 32'h0);
			check("arith_work", rd, {24'h0, ds[i] ? 8'h3C : res});
		end
		// every bit position under both bit tests
		set_file(7'h20, 8'hA5);
		res = 8'hA5;
		for (i = 0; i < 16; i++) begin
			skp = (i >= 8) ? res[i % 8] : ~res[i % 8];
			bus_acc(1'b1, REG_PC, 32'h200);
			exec({(i >= 8) ? PAT_BSKIP_SET : PAT_BSKIP_CLR, 3'(i % 8), 7'h20});
			check("bit_pc", {19'h0, o_pc}, 32'h201 + {31'h0, skp});
			check("bit_lat", lat, base + (skp ? TCY : 0));
		end
		// call then branch with different page latch values
		bus_acc(1'b1, REG_PAGE, 32'h18);
		bus_acc(1'b1, REG_PC, 32'h0123);
		exec({PAT_CALL, 11'h5A5});
		check("call_lat", lat, base + TCY);
		check("call_pc", {19'h0, o_pc}, 32'h1DA5);
		bus_acc(1'b0, REG_STACK, 32'h0);
		check("call_push", rd, 32'h0124);
		bus_acc(1'b1, REG_PAGE, 32'h0F);
		exec({PAT_BRANCH, 11'h7FF});
		check("br_lat", lat, base + TCY);
		check("br_pc", {19'h0, o_pc}, 32'h0FFF);
		bus_acc(1'b0, REG_STACK, 32'h0);
		check("br_stack", rd, 32'h0124);
		// let the watchdog overflow, then clear it
		for (i = 0; i < 3000 && o_timeout_flag_n !== 1'b0; i++) @(posedge i_core_clk);
		check("wdt_tmo", {31'h0, o_timeout_flag_n}, 32'h0);
		exec(PAT_WDT_CLR);
		check("wdt_clr_tmo", {31'h0, o_timeout_flag_n}, 32'h1);
		check("wdt_clr_pd", {31'h0, o_powerdown_flag_n}, 32'h1);
		bus_acc(1'b0, REG_WDT, 32'h0);
		// a couple of prescaled ticks can land between the clear and this read
		check("wdt_clr_cnt", {31'h0, rd < 32'h4}, 32'h1);
		tally_and_finish();
	end
endmodule : mie_core_bench
`default_nettype wire
